/* File: bench/adc_read_sva.sv */
// concurrent checks on the converter pins and the axi read channel
// assumes one clock domain with a synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none

module adc_read_sva (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       cs_n,
  input wire logic       rd_n,
  input wire logic       upper_byte_select,
  input wire logic       busy_n,
  input wire logic [3:0] upper_nibble_outputs,
  input wire logic [7:0] shared_byte_outputs,
  input wire logic       data_oe,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ----------------------------------------
  // start gating and busy
  // ----------------------------------------
  // all three select pins low, seen as a fresh edge
  logic low_all;
  assign low_all = !cs_n && !rd_n && !upper_byte_select;

  property p_start; busy_n && low_all && !$past(low_all) |=> !busy_n; endproperty
  a_start: assert property (p_start) else $error("start not acknowledged by busy");
  property p_busy_len; $fell(busy_n) |-> ##66 !busy_n ##1 busy_n; endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy low time wrong");
  property p_no_start; !cs_n && !rd_n && upper_byte_select && busy_n |=> busy_n; endproperty
  a_no_start: assert property (p_no_start) else $error("upper read started a conversion");

  // ----------------------------------------
  // data outputs and the axi read answer
  // ----------------------------------------
  property p_oe; data_oe != $past(data_oe) |-> data_oe == (!$past(cs_n) && !$past(rd_n)); endproperty
  a_oe: assert property (p_oe) else $error("output enable not following select");
  property p_upper_hold; !$rose(busy_n) |-> $stable(upper_nibble_outputs); endproperty
  a_upper_hold: assert property (p_upper_hold) else $error("upper outputs moved off end of conversion");
  property p_shared_hold;
    !busy_n && !$past(upper_byte_select) && !$past(upper_byte_select, 2) |-> $stable(shared_byte_outputs);
  endproperty
  a_shared_hold: assert property (p_shared_hold) else $error("old low byte not held while busy");
  property p_mux;
    busy_n && $past(busy_n) && $past(upper_byte_select) |-> shared_byte_outputs == {4'h0, upper_nibble_outputs};
  endproperty
  a_mux: assert property (p_mux) else $error("upper byte read shows wrong bits");
  property p_ar; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
  a_ar: assert property (p_ar) else $error("read answer missing");

  // main scenarios reached
  c_conv: cover property ($fell(busy_n));
  c_upper: cover property (busy_n && $past(upper_byte_select));
  c_ignored: cover property (!busy_n && low_all && !$past(low_all));
endmodule : adc_read_sva

`default_nettype wire

/* File: bench/host_bus_model.sv */
// processor bus model driving chip select, read and byte select
// assumes callers enter each task just after a rising clock edge
`timescale 1ns/1ps
`default_nettype none

module host_bus_model #(
  parameter int GAP_CYC = 85 // conversion of 67 cycles plus an 18-cycle gap
) (
  input  wire logic        aclk,
  input  wire logic        busy_n,
  input  wire logic [11:0] data_bus,
  output logic             cs_n,
  output logic             rd_n,
  output logic             upper_byte_select
);
  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    upper_byte_select = 1'b0;
  end

  // wait-state read: stall until busy returns, then take the word
  task automatic wait_read(input logic ube, output logic [11:0] w);
    bit seen;
    seen = 1'b0;
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    upper_byte_select <= ube;
    repeat (200) begin
      @(posedge aclk);
      if (!busy_n) seen = 1'b1;
      else if (seen) break;
    end
    w = data_bus;
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    @(posedge aclk);
  endtask : wait_read

  // pipelined read: no stall, data taken once the outputs settle
  task automatic rom_read(input logic ube, output logic [11:0] w);
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    upper_byte_select <= ube;
    repeat (2) @(posedge aclk);
    w = data_bus;
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    upper_byte_select <= 1'b0;
    @(posedge aclk);
  endtask : rom_read

  // spacing between pipelined reads, never shortened
  task automatic gap();
    repeat (GAP_CYC) @(posedge aclk);
  endtask : gap
endmodule : host_bus_model

`default_nettype wire

/* File: bench/testbench.sv */
// self-checking bench: register bus, wait-state and pipelined reads
// assumes the host model on the pins and the checker bound below
`timescale 1ns/1ps
`default_nettype none

module testbench;
  typedef struct { logic bip; logic [11:0] code; logic [11:0] res; } row_t;
  logic                aclk, aresetn, cs_n, rd_n, upper_byte_select, busy_n, data_oe;
  logic [3:0]          upper_nibble_outputs, s_axi_wstrb;
  logic [7:0]          shared_byte_outputs, s_axi_awaddr, s_axi_araddr;
  adc_read_pkg::code_t analog_code;
  logic [11:0]         w;
  wire  [11:0]         data_bus;
  logic                s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic                s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0]         s_axi_wdata, s_axi_rdata;
  logic [1:0]          s_axi_bresp, s_axi_rresp;
  int                  mismatches, samples_checked;
  // ordinary cases: mode and core code beside the expected result
  row_t rows [4] = '{'{1'b0, 12'h5A3, 12'h5A3}, '{1'b0, 12'hFFF, 12'hFFF},
                     '{1'b1, 12'h800, 12'h000}, '{1'b1, 12'h123, 12'h923}};

  // released data pins float; only an enabled device drives them
  assign data_bus = data_oe ? {upper_nibble_outputs, shared_byte_outputs} : 12'hzzz;

  adc_parallel_read_control uut (.aclk, .aresetn, .cs_n, .rd_n, .upper_byte_select, .busy_n,
    .upper_nibble_outputs, .shared_byte_outputs, .data_oe, .analog_code, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  host_bus_model host (.aclk, .busy_n, .data_bus, .cs_n, .rd_n, .upper_byte_select);

  // ----------------------------------------
  // clock, compare and closing
  // ----------------------------------------
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic print_verdict();
    $display("checked=%0d mismatches=%0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict

  // hang guard: the whole sequence needs well under 3000 cycles
  initial begin
    repeat (3000) @(posedge aclk);
    mismatches++;
    print_verdict();
  end

  // ----------------------------------------
  // register bus master
  // ----------------------------------------
  // a missing answer is left to the watchdog; no answer may come early
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        chk(s_axi_bresp, er);
        break;
      end
    end
    chk({s_axi_awvalid, s_axi_wvalid}, 2'h0);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        chk(s_axi_rdata, d);
        chk(s_axi_rresp, er);
        break;
      end
    end
    chk(s_axi_arvalid, 1'b0);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask : axi_rd

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    aresetn = 1'b0;
    analog_code = 12'h000;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0000_0000_0000;
    s_axi_wstrb = 4'hF;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(busy_n, 1);
    chk(data_oe, 0);
    axi_rd(8'h00, 32'h0000_0002, 2'h0);
    axi_wr(8'h08, 32'h0000_0FFF, 2'h0);
    axi_rd(8'h08, 32'h0000_0000, 2'h0);
    axi_rd(8'h0C, 32'h0000_0000, 2'h0);
    axi_wr(8'h10, 32'h0000_0001, 2'h2);
    axi_rd(8'h10, 32'h0000_0000, 2'h2);
    $display("test reset done");
    foreach (rows[i]) begin
      axi_wr(8'h00, {30'h0, 1'b1, rows[i].bip}, 2'h0);
      analog_code <= rows[i].code;
      host.wait_read(1'b0, w);
      chk(w, rows[i].res);
      host.rom_read(1'b1, w);
      chk(w, {rows[i].res[11:8], 4'h0, rows[i].res[11:8]});
      axi_rd(8'h08, rows[i].res, 2'h0);
      axi_rd(8'h0C, i + 1, 2'h0);
      $display("test row %0d done", i);
    end
    // pipelined parallel: each read shows the result before it
    axi_wr(8'h00, 32'h0000_0002, 2'h0);
    analog_code <= 12'h3C5;
    host.rom_read(1'b0, w);
    chk(w, 12'h923);
    host.gap();
    analog_code <= 12'hA5A;
    host.rom_read(1'b0, w);
    chk(w, 12'h3C5);
    host.gap();
    // pipelined byte mode: start, upper nibble, then low byte
    analog_code <= 12'h6E1;
    host.rom_read(1'b0, w);
    chk(w[7:0], 8'h5A);
    host.gap();
    host.rom_read(1'b1, w);
    chk(w, 12'h606);
    host.rom_read(1'b0, w);
    chk(w, 12'h6E1);
    host.gap();
    $display("test pipelined done");
    // a second start while busy is ignored and flagged
    analog_code <= 12'h0F0;
    host.rom_read(1'b0, w);
    host.rom_read(1'b0, w);
    axi_rd(8'h04, 32'h0000_0005, 2'h0);
    host.gap();
    axi_rd(8'h0C, 32'h0000_0009, 2'h0);
    axi_wr(8'h04, 32'h0000_0004, 2'h0);
    axi_rd(8'h04, 32'h0000_0000, 2'h0);
    $display("test retrigger done");
    // reset in mid-conversion, then a clean start
    host.rom_read(1'b0, w);
    repeat (5) @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(busy_n, 1);
    chk(data_oe, 0);
    axi_rd(8'h08, 32'h0000_0000, 2'h0);
    analog_code <= 12'h246;
    host.wait_read(1'b0, w);
    chk(w, 12'h246);
    $display("test mid reset done");
    print_verdict();
  end
endmodule : testbench

bind adc_parallel_read_control adc_read_sva chk_i (.aclk, .aresetn, .cs_n, .rd_n, .upper_byte_select,
  .busy_n, .upper_nibble_outputs, .shared_byte_outputs, .data_oe, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid);

`default_nettype wire

/* File: design/adc_parallel_read_control.sv */
// top of the converter's parallel read interface: start gating,
// busy, output latch, byte multiplexer and an axi4-lite slave
// assumes pins are synchronous to aclk; the analog core supplies
// its code on analog_code, valid at the end of the timed conversion
//
// Function
// R1 - start needs chip select, read, byte-select low
// R2 - starts ignored while a conversion runs
// R3 - busy low exactly while converting
// R4 - wait-state host stalls until busy returns
// R5 - pipelined read starts conversion, shows previous result
// R6 - result right-justified, lsb rightmost
// R7 - byte-select steers result onto shared low outputs
// R8 - top nibble always on upper outputs when driving
// R9 - busy acknowledges start; old result shown meanwhile
// R10 - latch updated first, then busy returns high
// R11 - byte mode first read behaves as parallel
// R12 - byte-select read: no start, nibble low, rest zero
// R13 - pipelined second read returns new, starts again
// R14 - host spaces reads by conversion plus gap
// R15 - pipelined byte mode uses three reads
// R16 - host waits conversion time before third read
// R17 - conversion completes within its longest time
// R18 - unipolar natural binary, bipolar two's complement
// R19 - outputs float unless chip select and read low
//
// Chosen here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "adc_read_map.svh"

module adc_parallel_read_control (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  // converter pins
  input  wire logic                cs_n,
  input  wire logic                rd_n,
  input  wire logic                upper_byte_select,
  output logic                     busy_n,
  output logic [3:0]               upper_nibble_outputs,
  output logic [7:0]               shared_byte_outputs,
  output logic                     data_oe,
  // analog core result
  input  wire adc_read_pkg::code_t analog_code,
  // axi4-lite slave
  input  wire logic [7:0]          s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [7:0]          s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [1:0]          ctrl_q;
  logic                ignored_q;
  logic [15:0]         count_q;
  logic                start_prev_q;
  adc_read_pkg::code_t result_bits_q;
  logic                busy_n_q;
  logic [3:0]          upper_q;
  logic [7:0]          shared_q;
  logic                oe_q;

  logic                selected;
  logic                start_cond;
  logic                start_pulse;
  logic                free;
  logic                accept;
  logic                reading_upper;

  logic                conv_running;
  logic                conv_valid;
  logic                conv_ready;
  adc_read_pkg::code_t conv_data;
  logic                buf_valid;
  logic                buf_ready;
  adc_read_pkg::code_t buf_data;

  logic                aw_hold_q;
  logic [7:0]          aw_addr_q;
  logic                w_hold_q;
  logic [31:0]         w_data_q;
  logic [3:0]          w_strb_q;
  logic                bvalid_q;
  logic [1:0]          bresp_q;
  logic                rvalid_q;
  logic [31:0]         rdata_q;
  logic [1:0]          rresp_q;
  logic                do_write;
  logic                clr_ignored;

  // ----------------------------------------------------------------
  // start gating
  // ----------------------------------------------------------------

  // all three inputs low qualify a start; only the edge of that
  // condition counts, so a read held low through the end of a
  // conversion does not retrigger it
  assign selected      = !cs_n && !rd_n;
  assign start_cond    = selected && !upper_byte_select;  // [R1] [R12]
  assign start_pulse   = start_cond && !start_prev_q && ctrl_q[`CTRL_ENABLE_BIT];
  assign reading_upper = selected && upper_byte_select;

  // free only once the previous word has reached the output latch
  assign free   = !conv_running && !buf_valid;
  assign accept = start_pulse && free;  // [R2] [R5] [R13]

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_prev_q <= 1'b0;
    end else begin
      start_prev_q <= start_cond;
    end
  end

  // ----------------------------------------------------------------
  // conversion and result path
  // ----------------------------------------------------------------
  conv_timer u_conv_timer (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .start       (accept),
    .bipolar     (ctrl_q[`CTRL_BIPOLAR_BIT]),
    .analog_code (analog_code),
    .running     (conv_running),
    .out_valid   (conv_valid),
    .out_ready   (conv_ready),
    .out_data    (conv_data)
  );

  result_buffer u_result_buffer (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_valid  (conv_valid),
    .in_ready  (conv_ready),
    .in_data   (conv_data),
    .out_valid (buf_valid),
    .out_ready (buf_ready),
    .out_data  (buf_data)
  );

  // the latch must not change under an upper-byte read, else the
  // two bytes of one word could come from different conversions
  assign buf_ready = !reading_upper;

  // output latch keeps the previous result until the new one lands
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result_bits_q <= 12'h000;
    end else if (buf_valid && buf_ready) begin
      result_bits_q <= buf_data;  // [R10]
    end
  end

  // busy falls the edge after the start and rises only when the
  // buffer is empty, i.e. the latch already holds the new word
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_n_q <= 1'b1;
    end else begin
      busy_n_q <= !(accept || conv_running || buf_valid);  // [R3] [R9] [R10] [R4]
    end
  end

  // ----------------------------------------------------------------
  // data outputs
  // ----------------------------------------------------------------

  // registered drivers: one cycle of latency from the pins, traded
  // for glitch-free outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      oe_q     <= 1'b0;
      upper_q  <= 4'h0;
      shared_q <= 8'h00;
    end else begin
      oe_q     <= selected;  // [R19]
      upper_q  <= result_bits_q[11:8];  // [R8] [R6]
      shared_q <= adc_read_pkg::shared_mux(result_bits_q, upper_byte_select);  // [R7] [R11] [R12] [R15]
    end
  end

  assign busy_n               = busy_n_q;
  assign data_oe              = oe_q;
  assign upper_nibble_outputs = upper_q;
  assign shared_byte_outputs  = shared_q;

  // ----------------------------------------------------------------
  // status counters and flags
  // ----------------------------------------------------------------

  // a start lost to a running conversion is noted; set wins over
  // the write-one clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ignored_q <= 1'b0;
    end else if (start_pulse && !free) begin
      ignored_q <= 1'b1;  // [R2]
    end else if (clr_ignored) begin
      ignored_q <= 1'b0;
    end
  end

  // completed conversions, wraps
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_q <= 16'h0000;
    end else if (conv_valid && conv_ready) begin
      count_q <= count_q + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite write channels
  // ----------------------------------------------------------------

  // address and data are taken in either order and held until both
  // are in; nothing new is taken while a response waits
  assign s_axi_awready = !aw_hold_q && !bvalid_q;
  assign s_axi_wready  = !w_hold_q && !bvalid_q;
  assign do_write      = aw_hold_q && w_hold_q && !bvalid_q;
  assign clr_ignored   = do_write && (aw_addr_q == `REG_STATUS) && w_strb_q[0]
                         && w_data_q[`STAT_IGNORED_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      aw_addr_q <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end else if (do_write) begin
      aw_hold_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_hold_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (do_write) begin
      w_hold_q <= 1'b0;
    end
  end

  // response: unmapped offsets answer slverr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= `RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      unique case (aw_addr_q)
        `REG_CTRL, `REG_STATUS, `REG_RESULT, `REG_COUNT: bresp_q <= `RESP_OKAY;
        default:                                         bresp_q <= `RESP_SLVERR;
      endcase
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // control register: mode bits steer coding and start enable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= `CTRL_RESET_VALUE;
    end else if (do_write && (aw_addr_q == `REG_CTRL) && w_strb_q[0]) begin
      ctrl_q <= w_data_q[1:0];
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;

  // ----------------------------------------------------------------
  // axi4-lite read channels
  // ----------------------------------------------------------------
  assign s_axi_arready = !rvalid_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rresp_q  <= `RESP_OKAY;
      unique case (s_axi_araddr)
        `REG_CTRL:   rdata_q <= {30'h0000_0000, ctrl_q};
        `REG_STATUS: rdata_q <= {29'h0000_0000, ignored_q, buf_valid, !busy_n_q};
        `REG_RESULT: rdata_q <= {20'h0_0000, result_bits_q};
        `REG_COUNT:  rdata_q <= {16'h0000, count_q};
        default: begin
          rdata_q <= 32'h0000_0000;
          rresp_q <= `RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata  = rdata_q;
  assign s_axi_rresp  = rresp_q;

endmodule : adc_parallel_read_control

`default_nettype wire

/* File: design/adc_read_map.svh */
// register offsets, field positions, reset values and timing counts
// for the parallel read control block; included by bare name
`ifndef ADC_READ_MAP_SVH
`define ADC_READ_MAP_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses, one aligned word each)
// ----------------------------------------------------------------
`define REG_CTRL           8'h00
`define REG_STATUS         8'h04
`define REG_RESULT         8'h08
`define REG_COUNT          8'h0C

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define CTRL_BIPOLAR_BIT   0
`define CTRL_ENABLE_BIT    1
`define CTRL_RESET_VALUE   2'h2
`define STAT_BUSY_BIT      0
`define STAT_PENDING_BIT   1
`define STAT_IGNORED_BIT   2

// ----------------------------------------------------------------
// axi responses
// ----------------------------------------------------------------
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS      40
`define CONV_TIME_NS       2700
// longest time: round down to whole cycles
`define CONV_CYCLES        (`CONV_TIME_NS / `CLK_PERIOD_NS)

`endif

/* File: design/adc_read_pkg.sv */
// types and helpers shared by the parallel read control files
// assumes adc_read_map.svh supplies nothing needed here
package adc_read_pkg;

  typedef logic [11:0] code_t;
  typedef logic [7:0]  byte_t;

  typedef enum logic [1:0] {
    CONV_IDLE,
    CONV_RUN,
    CONV_HOLD
  } conv_state_t;

  // unipolar keeps natural binary; bipolar inverts the msb of the
  // offset-binary core code to give two's complement
  function automatic code_t encode_code(input code_t raw, input logic bipolar);
    encode_code = bipolar ? {~raw[11], raw[10:0]} : raw;
  endfunction : encode_code

  // shared low outputs: low byte, or the top nibble right-justified
  function automatic byte_t shared_mux(input code_t word, input logic upper_sel);
    shared_mux = upper_sel ? {4'h0, word[11:8]} : word[7:0];
  endfunction : shared_mux

endpackage : adc_read_pkg

/* File: design/conv_timer.sv */
// self-timed conversion sequencer: counts the conversion time,
// then offers the coded result until the buffer takes it
// assumes start is a one-cycle pulse given only while idle
`timescale 1ns/1ps
`default_nettype none
`include "adc_read_map.svh"

module conv_timer (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic                start,
  input  wire logic                bipolar,
  input  wire adc_read_pkg::code_t analog_code,
  output logic                     running,
  output logic                     out_valid,
  input  wire logic                out_ready,
  output adc_read_pkg::code_t      out_data
);

  // hold, buffer and busy stages take three of the counted cycles
  localparam logic [6:0] LAST_CYCLE = 7'(`CONV_CYCLES - 4);

  adc_read_pkg::conv_state_t state_q;
  logic [6:0]                cnt_q;
  adc_read_pkg::code_t       data_q;

  assign running   = (state_q != adc_read_pkg::CONV_IDLE);
  assign out_valid = (state_q == adc_read_pkg::CONV_HOLD);
  assign out_data  = data_q;

  // the hold state stalls the sequencer while the buffer is full,
  // so no finished word is dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= adc_read_pkg::CONV_IDLE;
      cnt_q   <= 7'h00;
      data_q  <= 12'h000;
    end else begin
      unique case (state_q)
        adc_read_pkg::CONV_IDLE: begin
          cnt_q <= 7'h00;
          if (start) state_q <= adc_read_pkg::CONV_RUN;
        end
        adc_read_pkg::CONV_RUN: begin
          if (cnt_q == LAST_CYCLE) begin  // [R17]
            data_q  <= adc_read_pkg::encode_code(analog_code, bipolar);  // [R18]
            state_q <= adc_read_pkg::CONV_HOLD;
          end else begin
            cnt_q <= cnt_q + 7'h01;
          end
        end
        adc_read_pkg::CONV_HOLD: begin
          if (out_ready) state_q <= adc_read_pkg::CONV_IDLE;
        end
        default: state_q <= adc_read_pkg::CONV_IDLE;
      endcase
    end
  end

endmodule : conv_timer

`default_nettype wire

/* File: design/result_buffer.sv */
// two-entry result buffer with valid/ready on both sides
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none

module result_buffer (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic                in_valid,
  output logic                     in_ready,
  input  wire adc_read_pkg::code_t in_data,
  output logic                     out_valid,
  input  wire logic                out_ready,
  output adc_read_pkg::code_t      out_data
);

  adc_read_pkg::code_t mem_q [2];
  logic                wr_ptr_q;
  logic                rd_ptr_q;
  logic [1:0]          count_q;
  logic                push;
  logic                pop;

  // honest full and empty from the entry count
  assign in_ready  = (count_q != 2'h2);
  assign out_valid = (count_q != 2'h0);
  assign out_data  = mem_q[rd_ptr_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // storage is not reset; only valid entries are ever read
  always_ff @(posedge aclk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  // pointers and count
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      count_q  <= 2'h0;
    end else begin
      if (push) wr_ptr_q <= ~wr_ptr_q;
      if (pop) rd_ptr_q <= ~rd_ptr_q;
      if (push && !pop) begin
        count_q <= count_q + 2'h1;
      end else if (pop && !push) begin
        count_q <= count_q - 2'h1;
      end
    end
  end

endmodule : result_buffer

`default_nettype wire
